//--- vsc_defs.vh
// timing and level constants for the valley switch-on controller
`ifndef VSC_DEFS_VH
`define VSC_DEFS_VH
`define VSC_CLK_MHZ          100
`define VSC_SS_TIME_US       16000
`define VSC_SS_STEPS         4
`define VSC_SS_STEP_CYC      ((`VSC_SS_TIME_US * `VSC_CLK_MHZ) / `VSC_SS_STEPS)
`define VSC_SS_REF0_MV       12'h708
`define VSC_SS_REF_STEP_MV   12'h226
`define VSC_EVAL_TIME_US     48000
`define VSC_EVAL_CYC         (`VSC_EVAL_TIME_US * `VSC_CLK_MHZ)
`define VSC_SKIP_MIN         3'h1
`define VSC_SKIP_MAX         3'h7
`define VSC_SKIP_RESET       3'h1
`define VSC_ZC_MAX           3'h7
`define VSC_OVP_BLANK_NS     1000
`define VSC_OVP_BLANK_CYC    ((`VSC_OVP_BLANK_NS * `VSC_CLK_MHZ) / 1000)
`define VSC_RS_LONG_NS       25000
`define VSC_RS_LONG_CYC      ((`VSC_RS_LONG_NS * `VSC_CLK_MHZ) / 1000)
`define VSC_RS_SHORT_NS      2500
`define VSC_RS_SHORT_CYC     ((`VSC_RS_SHORT_NS * `VSC_CLK_MHZ) / 1000)
`define VSC_PER_MAX_NS       50000
`define VSC_PER_MAX_CYC      ((`VSC_PER_MAX_NS * `VSC_CLK_MHZ) / 1000)
`define VSC_ON_MAX_NS        25000
`define VSC_ON_MAX_CYC       ((`VSC_ON_MAX_NS * `VSC_CLK_MHZ) / 1000)
`endif

//--- vsc_skip_counter.v
// valley-skip up/down counter with sticky feedback threshold flags
`default_nettype none
module vsc_skip_counter (
  input  wire       sys_clk,
  input  wire       rstn,
  input  wire       restart,
  input  wire       eval_tick,
  input  wire       above_low,
  input  wire       above_high,
  input  wire       above_reset,
  output reg  [2:0] skip_ff
);
`include "vsc_defs.vh"
  reg       seen_low_ff;
  reg       seen_high_ff;
  reg [2:0] nxt_skip;

  always @* begin
    nxt_skip = skip_ff;
    if (eval_tick) begin
      if (seen_high_ff || above_high) begin
        if (skip_ff > `VSC_SKIP_MIN) nxt_skip = skip_ff - 3'h1;
      end else if (!(seen_low_ff || above_low)) begin
        if (skip_ff < `VSC_SKIP_MAX) nxt_skip = skip_ff + 3'h1;
      end
    end
    if (above_reset || restart) nxt_skip = `VSC_SKIP_RESET;
  end

  always @(posedge sys_clk) begin
    if (!rstn) begin
      skip_ff      <= `VSC_SKIP_RESET;
      seen_low_ff  <= 1'b0;
      seen_high_ff <= 1'b0;
    end else begin
      skip_ff <= nxt_skip;
      // crossings in the update cycle belong to the closing period
      seen_low_ff  <= eval_tick ? 1'b0 : (seen_low_ff | above_low);
      seen_high_ff <= eval_tick ? 1'b0 : (seen_high_ff | above_high);
    end
  end
endmodule // vsc_skip_counter
`default_nettype wire

//--- vsc_switch_on.v
// switch-on timing: soft-start, valley counting, ring suppression, protections
`default_nettype none
`include "vsc_defs.vh"
module vsc_switch_on #(
  parameter SS_STEP_CYC = `VSC_SS_STEP_CYC,
  parameter EVAL_CYC    = `VSC_EVAL_CYC
) (
  input  wire        sys_clk,
  input  wire        rstn,
  input  wire        mains_ok,
  input  wire        fb_above_low,
  input  wire        fb_above_high,
  input  wire        fb_above_reset,
  input  wire        valley_detect,
  input  wire        zc_above_ovp,
  input  wire        zc_above_ring,
  input  wire        cs_above_fb,
  output reg         gate_ff,
  output reg  [11:0] fb_ref_mv_ff,
  output reg         soft_start_ff,
  output reg         olp_enable_ff,
  output reg         latched_off_ff,
  output wire [2:0]  skip_count,
  output reg  [2:0]  zc_count_ff
);
  localparam [15:0] RS_SHORT_CYC = `VSC_RS_SHORT_CYC;
  localparam [15:0] RS_LONG_CYC  = `VSC_RS_LONG_CYC;
  localparam ST_SS   = 2'h0;
  localparam ST_RUN  = 2'h1;
  localparam ST_HOLD = 2'h2;

  reg [1:0]  state_ff;
  reg [22:0] ss_cnt_ff;
  reg [1:0]  ss_step_ff;
  reg [28:0] eval_cnt_ff;
  reg [15:0] ovp_cnt_ff;
  reg [15:0] ring_cnt_ff;
  reg [15:0] per_cnt_ff;
  reg [15:0] on_cnt_ff;
  reg        valley_prev_ff;
  reg        ring_done_ff;
  reg        mains_prev_ff;
  wire       restart;
  wire       eval_tick;
  wire       gate_on;
  wire       gate_off;
  wire       valley_fall;
  wire       ovp_trip;

  assign restart     = mains_ok & ~mains_prev_ff;
  assign eval_tick   = (state_ff == ST_RUN) && (eval_cnt_ff == EVAL_CYC - 1);
  assign valley_fall = valley_prev_ff & ~valley_detect;
  // latch trips this edge: keep the gate from rising in the same cycle
  assign ovp_trip = ~gate_ff & zc_above_ovp & (ovp_cnt_ff >= `VSC_OVP_BLANK_CYC - 1);
  // on-instant is digital; off-instant follows the analog compare unless the maximum on-time ends it first
  assign gate_off = cs_above_fb | (on_cnt_ff >= `VSC_ON_MAX_CYC - 1);
  assign gate_on  = ~gate_ff & ring_done_ff & mains_ok & ~latched_off_ff & ~ovp_trip
                  & ((zc_count_ff >= skip_count)
                     | (per_cnt_ff >= `VSC_PER_MAX_CYC - 1));

  vsc_skip_counter u_skip (
    .sys_clk     (sys_clk),
    .rstn        (rstn),
    .restart     (restart),
    .eval_tick   (eval_tick),
    .above_low   (fb_above_low),
    .above_high  (fb_above_high),
    .above_reset (fb_above_reset),
    .skip_ff     (skip_count)
  );

  always @(posedge sys_clk) begin
    if (!rstn) begin
      state_ff       <= ST_SS;
      ss_cnt_ff      <= 23'h0;
      ss_step_ff     <= 2'h0;
      fb_ref_mv_ff   <= `VSC_SS_REF0_MV;
      soft_start_ff  <= 1'b1;
      olp_enable_ff  <= 1'b0;
      eval_cnt_ff    <= 29'h0;
      // idle level of mains_ok is high, so no false restart after reset
      mains_prev_ff  <= 1'b1;
    end else begin
      mains_prev_ff <= mains_ok;
      if (restart) begin
        state_ff      <= ST_SS;
        ss_cnt_ff     <= 23'h0;
        ss_step_ff    <= 2'h0;
        fb_ref_mv_ff  <= `VSC_SS_REF0_MV;
        soft_start_ff <= 1'b1;
        olp_enable_ff <= 1'b0;
        eval_cnt_ff   <= 29'h0;
      end else begin
        case (state_ff)
          ST_SS: begin
            olp_enable_ff <= 1'b0;
            if (ss_cnt_ff == SS_STEP_CYC - 1) begin
              ss_cnt_ff <= 23'h0;
              if (ss_step_ff == `VSC_SS_STEPS - 1) begin
                state_ff      <= ST_RUN;
                soft_start_ff <= 1'b0;
                olp_enable_ff <= 1'b1;
              end else begin
                ss_step_ff   <= ss_step_ff + 2'h1;
                fb_ref_mv_ff <= fb_ref_mv_ff + `VSC_SS_REF_STEP_MV;
              end
            end else begin
              ss_cnt_ff <= ss_cnt_ff + 23'h1;
            end
          end
          ST_RUN: begin
            eval_cnt_ff <= eval_tick ? 29'h0 : eval_cnt_ff + 29'h1;
          end
          default: state_ff <= ST_SS;
        endcase
      end
    end
  end

  always @(posedge sys_clk) begin
    if (!rstn) begin
      gate_ff        <= 1'b0;
      latched_off_ff <= 1'b0;
      zc_count_ff    <= 3'h0;
      valley_prev_ff <= 1'b0;
      ovp_cnt_ff     <= 16'h0;
      ring_cnt_ff    <= 16'h0;
      ring_done_ff   <= 1'b0;
      per_cnt_ff     <= 16'h0;
      on_cnt_ff      <= 16'h0;
    end else begin
      valley_prev_ff <= valley_detect;
      // only reset leaves the latch, so no later condition can restart the gate
      if (!gate_ff && zc_above_ovp) begin
        if (ovp_cnt_ff >= `VSC_OVP_BLANK_CYC - 1) latched_off_ff <= 1'b1;
        else ovp_cnt_ff <= ovp_cnt_ff + 16'h1;
      end else begin
        ovp_cnt_ff <= 16'h0;
      end
      per_cnt_ff <= (per_cnt_ff == 16'hFFFF) ? per_cnt_ff : per_cnt_ff + 16'h1;
      if (latched_off_ff || !mains_ok) begin
        gate_ff   <= 1'b0;
        on_cnt_ff <= 16'h0;
        if (gate_ff) begin
          ring_done_ff <= 1'b0;
          ring_cnt_ff  <= zc_above_ring ? RS_SHORT_CYC : RS_LONG_CYC;
        end
      end else if (gate_ff) begin
        on_cnt_ff <= on_cnt_ff + 16'h1;
        if (gate_off) begin
          gate_ff      <= 1'b0;
          ring_done_ff <= 1'b0;
          ring_cnt_ff  <= zc_above_ring ? RS_SHORT_CYC : RS_LONG_CYC;
        end
      end else begin
        if (ring_cnt_ff > 16'h1) ring_cnt_ff <= ring_cnt_ff - 16'h1;
        else ring_done_ff <= 1'b1;
        if (gate_on) begin
          gate_ff     <= 1'b1;
          on_cnt_ff   <= 16'h0;
          per_cnt_ff  <= 16'h0;
          zc_count_ff <= 3'h0;
        end else if (valley_fall && zc_count_ff != `VSC_ZC_MAX) begin
          zc_count_ff <= zc_count_ff + 3'h1;
        end
      end
    end
  end
endmodule // vsc_switch_on
`default_nettype wire

//--- vsc_switch_on_chk.sv
// port checker for the switch-on controller
`default_nettype none
module vsc_switch_on_chk #(
  parameter SS_STEP_CYC = 100,
  parameter EVAL_CYC    = 300
) (
  input wire logic sys_clk, rstn, mains_ok, fb_above_low, fb_above_high, fb_above_reset,
  input wire logic valley_detect, zc_above_ovp, zc_above_ring, cs_above_fb, gate_ff,
  input wire logic soft_start_ff, olp_enable_ff, latched_off_ff,
  input wire logic [11:0] fb_ref_mv_ff,
  input wire logic [2:0] skip_count, zc_count_ff
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  property p_ref;
    soft_start_ff |-> fb_ref_mv_ff inside {12'h708, 12'h92E, 12'hB54, 12'hD7A};
  endproperty
  a_ref: assert property (p_ref) else $error("bad soft-start ref");
  property p_olp; soft_start_ff |-> !olp_enable_ff; endproperty
  a_olp: assert property (p_olp) else $error("overload on in soft-start");
  property p_rng; skip_count inside {[3'h1:3'h7]}; endproperty
  a_rng: assert property (p_rng) else $error("skip out of range");
  property p_thr; fb_above_reset |-> ##[1:2] skip_count == 3'h1; endproperty
  a_thr: assert property (p_thr) else $error("skip not forced");
  // a valley seen during on-time would hide a missing clear, so look one cycle in
  property p_clr; gate_ff && $past(gate_ff) |-> zc_count_ff == 3'h0; endproperty
  a_clr: assert property (p_clr) else $error("count not cleared");
  property p_sup; $fell(gate_ff) |=> !gate_ff [*8]; endproperty
  a_sup: assert property (p_sup) else $error("gate back during suppression");
  property p_cs; gate_ff && cs_above_fb |=> !gate_ff; endproperty
  a_cs: assert property (p_cs) else $error("gate not cut by current");
  property p_lat; latched_off_ff |=> latched_off_ff && !gate_ff; endproperty
  a_lat: assert property (p_lat) else $error("latch released");
  c_on: cover property ($rose(gate_ff));
  c_ss: cover property ($fell(soft_start_ff));
  c_lat: cover property ($rose(latched_off_ff));
endmodule // vsc_switch_on_chk
bind vsc_switch_on vsc_switch_on_chk #(.SS_STEP_CYC(SS_STEP_CYC), .EVAL_CYC(EVAL_CYC))
  vsc_switch_on_chk_i (.*);
`default_nettype wire

//--- vsc_power_stage.sv
// behavioural power switch, current comparator and ringing winding
`default_nettype none
module vsc_power_stage (
  input  wire logic        sys_clk,
  input  wire logic        gate_ff,
  input  wire logic [15:0] on_cyc,
  input  wire logic [3:0]  n_valley,
  output var  logic        cs_above_fb,
  output var  logic        valley_detect
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] t_ff = 16'h0;
  logic        g_ff = 1'h0;
  initial {cs_above_fb, valley_detect} = 2'h0;
  // n_valley valley falls per off-time, one every 64 cycles; a stale count is masked on the switch edge
  always @(negedge sys_clk) begin
    t_ff <= (gate_ff != g_ff) ? 16'h0 : t_ff + 16'h1;
    g_ff <= gate_ff;
    cs_above_fb <= gate_ff && g_ff && (t_ff >= on_cyc);
    valley_detect <= !gate_ff && !g_ff && t_ff[5] && (t_ff[15:6] < {6'h0, n_valley});
  end
endmodule // vsc_power_stage
`default_nettype wire

//--- vsc_switch_on_tb_top.sv
// self-checking bench for the switch-on controller
`default_nettype none
module vsc_switch_on_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk = 1'h0, rstn = 1'h0, mains_ok = 1'h1, zc_above_ovp = 1'h0;
  logic fb_above_low = 1'h0, fb_above_high = 1'h0, fb_above_reset = 1'h0;
  logic zc_above_ring = 1'h1, gate_ff, cs_above_fb, valley_detect;
  logic soft_start_ff, olp_enable_ff, latched_off_ff;
  logic [11:0] fb_ref_mv_ff;
  logic [2:0]  skip_count, zc_count_ff;
  logic [15:0] on_cyc = 16'h64;
  logic [3:0]  n_valley = 4'h7;
  logic [5:0]  rows [12] = '{6'h02, 6'h03, 6'h04, 6'h05, 6'h06, 6'h07,
                             6'h07, 6'h27, 6'h36, 6'h39, 6'h31, 6'h02};
  int n_mismatch = 0, compares = 0, n;
  vsc_switch_on #(.SS_STEP_CYC(100), .EVAL_CYC(300)) vsc_switch_on_i (.*);
  vsc_power_stage vsc_power_stage_i (.*);
  task chk(input string nm, input logic [11:0] s, e);
    compares++;
    if (s !== e) begin
      $display("BAD %s expected %h seen %h", nm, e, s);
      n_mismatch++;
    end
  endtask
  task cyc(input int k);
    repeat (k) @(negedge sys_clk);
  endtask
  task len(input logic lvl, output int c);
    c = 0;
    wait (gate_ff === !lvl);
    wait (gate_ff === lvl);
    while (gate_ff === lvl && c < 9000) begin
      @(negedge sys_clk);
      c++;
    end
  endtask
  task close_out;
    $display("compares %0d n_mismatch %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial forever #5 sys_clk = ~sys_clk;
  initial begin
    #800000;
    n_mismatch++;
    close_out;
  end
  initial begin
    cyc(6);
    chk("ss", soft_start_ff, 12'h1);
    chk("skip", skip_count, 12'h1);
    rstn = 1'h1;
    for (int i = 0; i < 4; i++) begin
      cyc(i == 0 ? 50 : 100);
      chk("ref", fb_ref_mv_ff, 12'(12'h708 + 12'h226 * i));
    end
    cyc(100);
    chk("olp", olp_enable_ff, 12'h1);
    chk("ss", soft_start_ff, 12'h0);
    cyc(100);
    // pulses sit mid-period so each update sees exactly one row
    foreach (rows[i]) begin
      {fb_above_low, fb_above_high, fb_above_reset} = rows[i][5:3];
      cyc(2);
      {fb_above_low, fb_above_high, fb_above_reset} = 3'h0;
      cyc(168);
      chk("skip", skip_count, 12'(rows[i][2:0]));
      cyc(130);
    end
    fb_above_low = 1'h1;
    len(1'h0, n);
    chk("off", 12'(n inside {[250:256]}), 12'h1);
    zc_above_ring = 1'h0;
    n_valley = 4'h9;
    wait (gate_ff === 1'h0);
    cyc(1000);
    chk("zc", zc_count_ff, 12'h7);
    len(1'h0, n);
    chk("off", 12'(n inside {[2500:2506]}), 12'h1);
    {zc_above_ring, n_valley, fb_above_low} = 6'h2E;
    cyc(1800);
    fb_above_low = 1'h1;
    len(1'h0, n);
    chk("off", 12'(n inside {[448:454]}), 12'h1);
    n_valley = 4'h6;
    len(1'h0, n);
    chk("off", 12'(n inside {[4890:4905]}), 12'h1);
    on_cyc = 16'hFFFF;
    len(1'h1, n);
    chk("on", 12'(n inside {[2499:2502]}), 12'h1);
    on_cyc = 16'h64;
    mains_ok = 1'h0;
    cyc(200);
    mains_ok = 1'h1;
    cyc(3);
    chk("ref", fb_ref_mv_ff, 12'h708);
    chk("ss", soft_start_ff, 12'h1);
    chk("skip", skip_count, 12'h1);
    for (int i = 50; i < 250; i += 150) begin
      len(1'h1, n);
      zc_above_ovp = 1'h1;
      cyc(i);
      zc_above_ovp = 1'h0;
      chk("latch", latched_off_ff, 12'(i > 100));
    end
    cyc(6000);
    chk("gate", gate_ff, 12'h0);
    close_out;
  end
endmodule // vsc_switch_on_tb_top
`default_nettype wire
